// file: src/csi_pkg.sv
// shared constants and types for the clocked serial interface
package csi_pkg;

   // link clock feeding the shift logic and the internal shift clock divider
   localparam int LINK_CLK_PERIOD_NS = 30;
   // least time of each internal shift clock phase
   localparam int SCK_HALF_NS        = 120;
   localparam int SCK_HALF_CYC       =
      (SCK_HALF_NS + LINK_CLK_PERIOD_NS - 1) / LINK_CLK_PERIOD_NS;
   localparam int DIV_W              = 4;
   localparam logic [DIV_W-1:0] SCK_DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);

   // word widths in bits
   localparam logic [3:0] BITS_NARROW = 4'h4;
   localparam logic [3:0] BITS_WIDE   = 4'h8;

   // reset values
   localparam logic [7:0] BUF_RESET  = 8'h00;
   localparam logic [3:0] NIB_RESET  = 4'h0;
   localparam logic       SCK_IDLE   = 1'b1;
   localparam logic       SO_IDLE    = 1'b1;

   // field positions of the configuration word carried to the link side
   localparam int CFG_EN  = 0;
   localparam int CFG_EXT = 1;
   localparam int CFG_TXO = 2;
   localparam int CFG_RXO = 3;
   localparam int CFG_W8  = 4;
   localparam int CFG_TRL = 5;
   localparam int CFG_W   = 6;

   // content held by the shared buffer
   typedef enum logic [1:0] {BUF_EMPTY, BUF_RXDATA, BUF_TXDATA} csi_buf_t;

   // link side sequencer
   typedef enum logic [1:0] {L_IDLE, L_REQ, L_SHIFT} csi_link_t;

endpackage

// file: src/csi_serial_if.sv
// clocked serial interface: cpu-side buffer and link-side shifter
`timescale 1ns/1ps
`default_nettype none

module csi_serial_if
   import csi_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       clk_link,
   input  wire logic       word_width_select,
   input  wire logic       direction_select,
   input  wire logic       transfer_enable,
   input  wire logic       extClockSelect,
   input  wire logic       trailingEdgeSelect,
   input  wire logic       bufWrStb,
   input  wire logic [3:0] bufWrData,
   input  wire logic       bufRdStb,
   output logic      [3:0] bufRdData,
   output logic            transfer_active_flag,
   output logic            shift_ended_flag,
   output logic            buffer_event_irq,
   input  wire logic       sckIn,
   output logic            sckOut,
   output logic            sckOe_n,
   output logic            soOut,
   output logic            soOe_n,
   input  wire logic       siIn
);

   // ---------------- cpu side ----------------
   logic              w8;
   logic              txOnly;
   logic              rxOnly;
   logic [CFG_W-1:0]  cfgSys;
   logic [1:0]        reqSync;
   logic [1:0]        busySync;
   logic              pending;
   logic              canDep;

   csi_buf_t          bufState_reg, bufState_next;
   logic [7:0]        buf_reg, buf_next;
   logic [7:0]        txHold_reg, txHold_next;
   logic [3:0]        rdData_reg, rdData_next;
   logic [2:0]        modePrev_reg, modePrev_next;
   logic              nibHi_reg, nibHi_next;
   logic              irq_reg, irq_next;
   logic              sef_reg, sef_next;
   logic              dep_reg, dep_next;
   logic              ackTgl_reg, ackTgl_next;

   // ---------------- link side ----------------
   logic [1:0]        rstSync;
   logic              linkRst;
   logic [CFG_W-1:0]  cfgS1, cfgS2;
   logic              ackS1, ackS2;
   logic              sckS1, sckS2, sckS3;
   logic              siS1, siS2;

   csi_link_t         lState_reg, lState_next;
   logic [7:0]        shift_reg, shift_next;
   logic [7:0]        rxHold_reg, rxHold_next;
   logic [3:0]        bitCnt_reg, bitCnt_next;
   logic [DIV_W-1:0]  div_reg, div_next;
   logic              sck_reg, sck_next;
   logic              so_reg, so_next;
   logic              reqTgl_reg, reqTgl_next;
   logic              rxFlag_reg, rxFlag_next;
   logic              stop_reg, stop_next;
   logic              busy_reg, busy_next;

   assign w8     = word_width_select;
   assign txOnly = !direction_select;
   assign rxOnly = direction_select && !word_width_select;

   always_comb begin
      cfgSys          = '0;
      cfgSys[CFG_EN]  = transfer_enable;
      cfgSys[CFG_EXT] = extClockSelect;
      cfgSys[CFG_TXO] = txOnly;
      cfgSys[CFG_RXO] = rxOnly;
      cfgSys[CFG_W8]  = w8;
      cfgSys[CFG_TRL] = trailingEdgeSelect;
   end

   // request toggle and busy level come from the link clock
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reqSync  <= 2'h0;
         busySync <= 2'h0;
      end else begin
         reqSync  <= {reqSync[0], reqTgl_reg};
         busySync <= {busySync[0], busy_reg};
      end
   end

   // rxHold/rxFlag/stop stay still while a request is pending
   assign pending = reqSync[1] != ackTgl_reg;
   assign canDep  = extClockSelect || bufState_reg != BUF_RXDATA;

   always_comb begin
      bufState_next = bufState_reg;
      buf_next      = buf_reg;
      txHold_next   = txHold_reg;
      rdData_next   = rdData_reg;
      nibHi_next    = nibHi_reg;
      irq_next      = irq_reg;
      sef_next      = sef_reg;
      dep_next      = dep_reg;
      ackTgl_next   = ackTgl_reg;
      modePrev_next = {extClockSelect, direction_select, w8};
      if (modePrev_next != modePrev_reg) begin
         buf_next      = BUF_RESET;
         bufState_next = BUF_EMPTY;
         nibHi_next    = 1'b0;
         irq_next      = 1'b0;
         dep_next      = 1'b0;
      end else begin
         if (bufWrStb && !rxOnly) begin
            sef_next = 1'b0;
            if (w8 && !nibHi_reg) begin
               buf_next[3:0] = bufWrData;
               nibHi_next    = 1'b1;
            end else begin
               if (w8)
                  buf_next[7:4] = bufWrData;
               else
                  buf_next = {NIB_RESET, bufWrData};
               nibHi_next    = 1'b0;
               bufState_next = BUF_TXDATA;
               if (txOnly)
                  irq_next = 1'b0;
            end
         end else if (bufRdStb) begin
            sef_next = 1'b0;
            rdData_next = (w8 && nibHi_reg) ? buf_reg[7:4] : buf_reg[3:0];
            if (w8 && !nibHi_reg) begin
               nibHi_next = 1'b1;
            end else begin
               nibHi_next = 1'b0;
               if (bufState_reg == BUF_RXDATA) begin
                  bufState_next = BUF_EMPTY;
                  irq_next      = 1'b0;
               end
            end
         end
         // hardware events win over the clears above
         if (pending) begin
            if (rxFlag_reg && !dep_reg) begin
               if (canDep) begin
                  buf_next      = rxHold_reg;
                  bufState_next = BUF_RXDATA;
                  irq_next      = 1'b1;
                  sef_next      = 1'b1;
                  nibHi_next    = 1'b0;
                  if (rxOnly || extClockSelect || stop_reg)
                     ackTgl_next = reqSync[1];
                  else
                     dep_next = 1'b1;
               end
            end else if (bufState_reg == BUF_TXDATA && !bufWrStb) begin
               txHold_next   = buf_reg;
               bufState_next = BUF_EMPTY;
               ackTgl_next   = reqSync[1];
               dep_next      = 1'b0;
               sef_next      = 1'b1;
               if (txOnly) begin
                  irq_next   = 1'b1;
                  nibHi_next = 1'b0;
               end
            end else if (extClockSelect) begin
               // no fresh word: the shifter repeats its last one
               ackTgl_next = reqSync[1];
               dep_next    = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         bufState_reg <= BUF_EMPTY;
         buf_reg      <= BUF_RESET;
         txHold_reg   <= BUF_RESET;
         rdData_reg   <= NIB_RESET;
         modePrev_reg <= 3'h0;
         nibHi_reg    <= 1'b0;
         irq_reg      <= 1'b0;
         sef_reg      <= 1'b0;
         dep_reg      <= 1'b0;
         ackTgl_reg   <= 1'b0;
      end else begin
         bufState_reg <= bufState_next;
         buf_reg      <= buf_next;
         txHold_reg   <= txHold_next;
         rdData_reg   <= rdData_next;
         modePrev_reg <= modePrev_next;
         nibHi_reg    <= nibHi_next;
         irq_reg      <= irq_next;
         sef_reg      <= sef_next;
         dep_reg      <= dep_next;
         ackTgl_reg   <= ackTgl_next;
      end
   end

   assign bufRdData            = rdData_reg;
   assign buffer_event_irq     = irq_reg;
   assign shift_ended_flag     = sef_reg;
   assign transfer_active_flag = busySync[1];

   // ---------------- link clock domain ----------------
   // reset is carried over so the link side leaves reset on its own edge
   always_ff @(posedge clk_link) begin
      rstSync <= {rstSync[0], sys_rst};
   end
   assign linkRst = rstSync[1];

   // pins sampled twice; sckS3 is only an edge reference
   always_ff @(posedge clk_link) begin
      if (linkRst) begin
         cfgS1 <= '0;
         cfgS2 <= '0;
         ackS1 <= 1'b0;
         ackS2 <= 1'b0;
         sckS1 <= SCK_IDLE;
         sckS2 <= SCK_IDLE;
         sckS3 <= SCK_IDLE;
         siS1  <= 1'b0;
         siS2  <= 1'b0;
      end else begin
         cfgS1 <= cfgSys;
         cfgS2 <= cfgS1;
         ackS1 <= ackTgl_reg;
         ackS2 <= ackS1;
         sckS1 <= sckIn;
         sckS2 <= sckS1;
         sckS3 <= sckS2;
         siS1  <= siIn;
         siS2  <= siS1;
      end
   end

   logic       lEn, lExt, lTxo, lRxo, lW8;
   logic       sampleFall, tick, fallEdge, riseEdge;
   logic [3:0] wordBits, cntNow;
   logic [7:0] shifted;

   assign lEn  = cfgS2[CFG_EN];
   assign lExt = cfgS2[CFG_EXT];
   assign lTxo = cfgS2[CFG_TXO];
   assign lRxo = cfgS2[CFG_RXO];
   assign lW8  = cfgS2[CFG_W8];
   // only pure receive may choose the edge; duplex samples on trailing
   assign sampleFall = lRxo && !cfgS2[CFG_TRL];
   assign wordBits   = lW8 ? BITS_WIDE : BITS_NARROW;
   assign tick       = div_reg == SCK_DIV_LAST;
   assign fallEdge   = lExt ? (sckS3 && !sckS2) : (tick && sck_reg);
   assign riseEdge   = lExt ? (!sckS3 && sckS2) : (tick && !sck_reg);
   assign shifted    = lW8 ? {siS2, shift_reg[7:1]}
                           : {NIB_RESET, siS2, shift_reg[3:1]};

   always_comb begin
      lState_next = lState_reg;
      shift_next  = shift_reg;
      rxHold_next = rxHold_reg;
      bitCnt_next = bitCnt_reg;
      div_next    = div_reg;
      sck_next    = sck_reg;
      so_next     = so_reg;
      reqTgl_next = reqTgl_reg;
      rxFlag_next = rxFlag_reg;
      stop_next   = stop_reg;
      busy_next   = busy_reg;
      cntNow      = bitCnt_reg;
      case (lState_reg)
         L_IDLE: begin
            sck_next = SCK_IDLE;
            div_next = '0;
            if (lEn) begin
               busy_next   = 1'b1;
               bitCnt_next = 4'h0;
               if (!lRxo) begin
                  reqTgl_next = !reqTgl_reg;
                  rxFlag_next = 1'b0;
                  stop_next   = 1'b0;
                  lState_next = L_REQ;
               end else begin
                  lState_next = L_SHIFT;
               end
            end
         end
         L_REQ: begin
            // internal clock parked high until the buffer answers
            div_next = '0;
            if (ackS2 == reqTgl_reg) begin
               if (stop_reg) begin
                  busy_next   = 1'b0;
                  lState_next = L_IDLE;
               end else begin
                  if (!lRxo)
                     shift_next = txHold_reg;
                  bitCnt_next = 4'h0;
                  lState_next = L_SHIFT;
               end
            end
         end
         L_SHIFT: begin
            div_next = tick ? '0 : div_reg + 1'b1;
            if (!lExt && tick)
               sck_next = !sck_reg;
            if (fallEdge) begin
               if (!lRxo)
                  so_next = shift_reg[0];
               if (sampleFall) begin
                  shift_next  = shifted;
                  bitCnt_next = bitCnt_reg + 4'h1;
               end
            end
            if (riseEdge) begin
               if (!sampleFall) begin
                  shift_next = shifted;
                  cntNow     = bitCnt_reg + 4'h1;
               end
               bitCnt_next = cntNow;
               if (cntNow == wordBits) begin
                  rxHold_next = shift_next;
                  // enable is judged only at a word boundary
                  if (lEn || !lTxo) begin
                     reqTgl_next = !reqTgl_reg;
                     rxFlag_next = !lTxo;
                     stop_next   = !lEn;
                     lState_next = L_REQ;
                  end else begin
                     busy_next   = 1'b0;
                     lState_next = L_IDLE;
                  end
               end
            end
            // external clock: stop at a word boundary before the word begins
            if (lExt && !lEn && bitCnt_reg == 4'h0 && sckS2 && !riseEdge) begin
               busy_next   = 1'b0;
               lState_next = L_IDLE;
            end
         end
         default: lState_next = L_IDLE;
      endcase
   end

   always_ff @(posedge clk_link) begin
      if (linkRst) begin
         lState_reg <= L_IDLE;
         shift_reg  <= BUF_RESET;
         rxHold_reg <= BUF_RESET;
         bitCnt_reg <= 4'h0;
         div_reg    <= '0;
         sck_reg    <= SCK_IDLE;
         so_reg     <= SO_IDLE;
         reqTgl_reg <= 1'b0;
         rxFlag_reg <= 1'b0;
         stop_reg   <= 1'b0;
         busy_reg   <= 1'b0;
      end else begin
         lState_reg <= lState_next;
         shift_reg  <= shift_next;
         rxHold_reg <= rxHold_next;
         bitCnt_reg <= bitCnt_next;
         div_reg    <= div_next;
         sck_reg    <= sck_next;
         so_reg     <= so_next;
         reqTgl_reg <= reqTgl_next;
         rxFlag_reg <= rxFlag_next;
         stop_reg   <= stop_next;
         busy_reg   <= busy_next;
      end
   end

   assign sckOut  = sck_reg;
   assign sckOe_n = lExt;
   assign soOut   = so_reg;
   assign soOe_n  = lRxo;

endmodule

`default_nettype wire

// file: tb/csi_port_assertions.sv
// port checker for the clocked serial interface
`timescale 1ns/1ps
`default_nettype none
module csi_port_assertions (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       clk_link,
   input wire logic       word_width_select,
   input wire logic       direction_select,
   input wire logic       transfer_enable,
   input wire logic       extClockSelect,
   input wire logic       bufWrStb,
   input wire logic       bufRdStb,
   input wire logic [3:0] bufRdData,
   input wire logic       transfer_active_flag,
   input wire logic       shift_ended_flag,
   input wire logic       buffer_event_irq,
   input wire logic       sckOut,
   input wire logic       soOe_n
);
   // mode bits reach the link side through a synchroniser
   sequence txHeld;
      (!direction_select)[*8];
   endsequence
   sequence rxNarrowHeld;
      (direction_select && !word_width_select)[*8];
   endsequence
   sequence idleHeld;
      (!transfer_enable && !transfer_active_flag)[*8];
   endsequence
   // low nibble now, high nibble two cycles on
   sequence wordWritten;
      buffer_event_irq && bufWrStb && !direction_select && word_width_select
      && !extClockSelect ##2 bufWrStb;
   endsequence
   rd_data_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      !bufRdStb |=> $stable(bufRdData)) else $error("read data moved");
   rd_clears_event_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst) buffer_event_irq && bufRdStb && !bufWrStb
      && direction_select && !word_width_select && !extClockSelect
      |=> !buffer_event_irq) else $error("read left event set");
   wr_clears_event_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst) wordWritten |=> !buffer_event_irq)
      else $error("write left event set");
   tx_drives_so_a: assert property (@(posedge clk_link)
      disable iff (sys_rst) txHeld |-> !soOe_n)
      else $error("serial out not driven");
   rx_frees_so_a: assert property (@(posedge clk_link)
      disable iff (sys_rst) rxNarrowHeld |-> soOe_n)
      else $error("serial out driven in receive");
   sck_idle_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst) idleHeld |-> sckOut)
      else $error("shift clock not parked high");
   active_drop_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst) $fell(transfer_active_flag) |-> !transfer_enable)
      else $error("active dropped while enabled");
   end_flag_clr_a: assert property (@(posedge clk_sys)
      disable iff (sys_rst) shift_ended_flag && bufRdStb
      |=> !shift_ended_flag) else $error("shift ended not cleared");
   tx_event_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(transfer_active_flag) && !direction_select && !extClockSelect
      |-> ##[0:100] buffer_event_irq) else $error("no empty event");
endmodule
bind csi_serial_if csi_port_assertions u_chk (
   .clk_sys, .sys_rst, .clk_link, .word_width_select, .direction_select,
   .transfer_enable, .extClockSelect, .bufWrStb, .bufRdStb, .bufRdData,
   .transfer_active_flag, .shift_ended_flag, .buffer_event_irq, .sckOut,
   .soOe_n
);
`default_nettype wire

// file: tb/csi_serial_peer.sv
// peer model across the shift clock, serial out and serial in pins
`timescale 1ns/1ps
`default_nettype none
module csi_serial_peer (
   input  wire logic        sck,
   input  wire logic        so,
   input  wire logic        chgOnRise,
   input  wire logic        rstIdx,
   input  wire logic [15:0] pat,
   input  wire logic        extGo,
   output logic             si,
   output logic             extSck,
   output logic      [15:0] cap,
   output logic      [7:0]  edges
);
   logic [3:0] idx;
   // stands high between bursts; phases far above the pin synchroniser
   initial begin
      extSck = 1'b1;
      forever begin
         @(posedge extGo);
         repeat (4) begin
            #240 extSck = 1'b0;
            #240 extSck = 1'b1;
         end
      end
   end
   // bit moves on the edge opposite to the one the device samples
   always @(posedge sck or negedge sck or posedge rstIdx) begin
      if (rstIdx) begin
         idx = chgOnRise ? 4'h1 : 4'h0;
         si = pat[0];
         cap = 16'h0000;
         edges = 8'h00;
      end else if (sck) begin
         edges = edges + 8'h01;
         cap = {so, cap[15:1]};
         if (chgOnRise) begin
            si = pat[idx];
            idx = idx + 4'h1;
         end
      end else if (!chgOnRise) begin
         si = pat[idx];
         idx = idx + 4'h1;
      end
   end
endmodule
`default_nettype wire

// file: tb/test_clocked_serial_interface.sv
// bench: buffer calls with expected values against the peer model
`timescale 1ns/1ps
`default_nettype none
module test_clocked_serial_interface
   import csi_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        clk_link = 1'b0;
   logic        sys_rst = 1'b1;
   logic        word_width_select = 1'b0;
   logic        direction_select = 1'b0;
   logic        transfer_enable = 1'b0;
   logic        extClockSelect = 1'b0;
   logic        trailingEdgeSelect = 1'b0;
   logic        bufWrStb = 1'b0;
   logic        bufRdStb = 1'b0;
   logic [3:0]  bufWrData = 4'h0;
   logic [3:0]  bufRdData;
   logic        transfer_active_flag, shift_ended_flag, buffer_event_irq;
   logic        sckOut, sckOe_n, soOut, soOe_n, siIn, extSck;
   logic        chgOnRise = 1'b1;
   logic        rstIdx = 1'b0;
   logic        extGo = 1'b0;
   logic [15:0] pat = 16'h0000;
   logic [15:0] cap;
   logic [7:0]  edges;
   int          error_cnt = 0;
   int          total_checks = 0;
   int          cycles = 0;
   wire logic   sckIn = sckOe_n ? extSck : sckOut;
   wire logic   soLine = soOe_n ? 1'b1 : soOut;
   csi_serial_if dut (
      .clk_sys, .sys_rst, .clk_link, .word_width_select, .direction_select,
      .transfer_enable, .extClockSelect, .trailingEdgeSelect, .bufWrStb,
      .bufWrData, .bufRdStb, .bufRdData, .transfer_active_flag,
      .shift_ended_flag, .buffer_event_irq, .sckIn, .sckOut, .sckOe_n,
      .soOut, .soOe_n, .siIn
   );
   csi_serial_peer peer (
      .sck(sckIn), .so(soLine), .chgOnRise, .rstIdx, .pat, .extGo,
      .si(siIn), .extSck, .cap, .edges
   );
   always #5 clk_sys = ~clk_sys;
   initial begin
      #2.7;
      forever #15 clk_link = ~clk_link;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles > 20000) begin
         error_cnt++;
         $display("Error run exceeded %0d cycles", cycles);
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic put(input logic [3:0] d);
      @(negedge clk_sys);
      bufWrStb = 1'b1;
      bufWrData = d;
      @(negedge clk_sys);
      bufWrStb = 1'b0;
   endtask
   task automatic get(input logic [3:0] exp);
      @(negedge clk_sys);
      bufRdStb = 1'b1;
      @(negedge clk_sys);
      bufRdStb = 1'b0;
      chk("read nibble", {12'h000, bufRdData}, {12'h000, exp});
   endtask
   task automatic waitLvl(input logic onIrq, v, input string what);
      int n;
      n = 0;
      while ((onIrq ? buffer_event_irq : transfer_active_flag) !== v
             && n < 3000) begin
         @(negedge clk_sys);
         n++;
      end
      chk(what, 16'(n < 3000), 16'h0001);
   endtask
   // peer held cleared while the mode crosses to the link side
   task automatic setMode(input logic w, d, e, t);
      @(negedge clk_sys);
      word_width_select = w;
      direction_select = d;
      extClockSelect = e;
      trailingEdgeSelect = t;
      chgOnRise = !t;
      rstIdx = 1'b1;
      repeat (20) @(negedge clk_sys);
      rstIdx = 1'b0;
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      // held past the link side's reset synchroniser
      repeat (12) @(negedge clk_sys);
      sys_rst = 1'b0;
      chk("reset outputs", {7'h00, bufRdData, buffer_event_irq,
          shift_ended_flag, transfer_active_flag, sckOut, soOut},
          {7'h00, BUF_RESET[3:0], 3'b000, SCK_IDLE, SO_IDLE});
      setMode(1'b1, 1'b0, 1'b0, 1'b0);
      put(4'h5);
      put(4'hA);
      transfer_enable = 1'b1;
      waitLvl(1'b1, 1'b1, "empty event");
      repeat (300) @(negedge clk_sys);
      chk("edges waiting", {8'h00, edges}, 16'h0008);
      chk("clock parked", {15'h0000, sckIn}, 16'h0001);
      put(4'hC);
      put(4'h3);
      chk("event cleared", {15'h0000, buffer_event_irq}, 16'h0000);
      waitLvl(1'b1, 1'b1, "second empty");
      transfer_enable = 1'b0;
      waitLvl(1'b0, 1'b0, "tx stopped");
      chk("tx edges", {8'h00, edges}, 16'h0010);
      chk("sent bits", cap, 16'h3CA5);
      $display("test transmit done");
      setMode(1'b0, 1'b0, 1'b0, 1'b0);
      put(4'hB);
      setMode(1'b0, 1'b1, 1'b0, 1'b0);
      get(BUF_RESET[3:0]);
      put(4'hF);
      get(BUF_RESET[3:0]);
      $display("test discard done");
      for (int t = 0; t < 2; t++) begin
         pat = 16'h0069;
         setMode(1'b0, 1'b1, 1'b0, t[0]);
         transfer_enable = 1'b1;
         waitLvl(1'b1, 1'b1, "full event");
         transfer_enable = 1'b0;
         repeat (300) @(negedge clk_sys);
         chk("edges unread", {8'h00, edges}, 16'h0008);
         chk("still active", {15'h0000, transfer_active_flag}, 16'h0001);
         get(4'h9);
         waitLvl(1'b0, 1'b0, "rx stopped");
         get(4'h6);
         $display("test receive done");
      end
      // duplex: word stored, clock parked until the next full write
      pat = 16'h96C3;
      setMode(1'b1, 1'b1, 1'b0, 1'b1);
      put(4'h1);
      put(4'hE);
      transfer_enable = 1'b1;
      waitLvl(1'b1, 1'b1, "duplex full");
      chk("shift ended", {15'h0000, shift_ended_flag}, 16'h0001);
      get(4'h3);
      get(4'hC);
      repeat (100) @(negedge clk_sys);
      chk("duplex waiting", {8'h00, edges}, 16'h0008);
      put(4'h2);
      put(4'hD);
      transfer_enable = 1'b0;
      waitLvl(1'b0, 1'b0, "duplex stopped");
      get(4'h6);
      get(4'h9);
      chk("duplex sent", cap, 16'hD2E1);
      chk("duplex edges", {8'h00, edges}, 16'h0010);
      $display("test duplex done");
      setMode(1'b0, 1'b0, 1'b1, 1'b0);
      put(4'h7);
      transfer_enable = 1'b1;
      repeat (20) @(negedge clk_sys);
      extGo = 1'b1;
      @(negedge clk_sys);
      extGo = 1'b0;
      repeat (250) @(negedge clk_sys);
      extGo = 1'b1;
      repeat (50) @(negedge clk_sys);
      extGo = 1'b0;
      transfer_enable = 1'b0;
      waitLvl(1'b0, 1'b0, "dummy sent");
      chk("dummy repeat", cap, 16'h7700);
      chk("ext edges", {8'h00, edges}, 16'h0008);
      $display("test external done");
      // external receive: read in time, then enable cleared between words
      pat = 16'h000C;
      setMode(1'b0, 1'b1, 1'b1, 1'b0);
      chk("clock pin freed", {15'h0000, sckOe_n}, 16'h0001);
      transfer_enable = 1'b1;
      repeat (20) @(negedge clk_sys);
      extGo = 1'b1;
      @(negedge clk_sys);
      extGo = 1'b0;
      waitLvl(1'b1, 1'b1, "ext full");
      get(4'hC);
      transfer_enable = 1'b0;
      waitLvl(1'b0, 1'b0, "ext rx stopped");
      chk("ext rx edges", {8'h00, edges}, 16'h0004);
      $display("test external receive done");
      end_of_test();
   end
endmodule
`default_nettype wire
